/* core/pct_top.sv */
// Pulse capture timer with AXI4-Lite register access
module pct_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // Write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // Read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Pulse input and chip stop
  input wire logic pulse_input_pin,
  input wire logic stop_mode_req,
  // Interrupt
  output logic capture_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  pct_event_if ev ();

  logic aw_got_q;
  logic [7:0] aw_addr_q;
  logic w_got_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic [pct_pkg::TCR_W-1:0] timer_control_reg_q;
  logic [pct_pkg::TCR_W-1:0] tcr_d;
  logic edge_polarity_select_q;
  logic [pct_pkg::CNT_W-1:0] period_capture_reg_q;
  logic [pct_pkg::CNT_W-1:0] period_d;
  logic [pct_pkg::CNT_W-1:0] width_capture_reg_q;
  logic [pct_pkg::CNT_W-1:0] width_d;
  logic [pct_pkg::CNT_W-1:0] cnt_q;
  logic [pct_pkg::CNT_W-1:0] cnt_d;
  logic [pct_pkg::STAT_W-1:0] stat_q;
  logic [pct_pkg::STAT_W-1:0] mask_q;
  pct_pkg::pct_state_t state_q;
  pct_pkg::pct_state_t state_d;
  logic ev_cap;
  logic ev_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  wire run_bit = timer_control_reg_q[pct_pkg::TCR_RUN];
  wire [2:0] source_clock_select = timer_control_reg_q[pct_pkg::TCR_CK_LSB +: 3];
  wire operating_mode_select = timer_control_reg_q[pct_pkg::TCR_MODE];
  wire auto_capture_enable = timer_control_reg_q[pct_pkg::TCR_AUTO_CAPTURE_ENABLE];
  wire cap_mode = operating_mode_select;
  wire width_edge = edge_polarity_select_q ? ev.rise : ev.fall;
  wire period_edge = edge_polarity_select_q ? ev.fall : ev.rise;
  wire tmr_step = (source_clock_select == pct_pkg::CK_EXTERNAL) ? width_edge : ev.tick;
  wire [pct_pkg::CNT_W-1:0] cnt_inc = cnt_q + 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  pct_edge_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pulse_input_pin(pulse_input_pin),
    .ev(ev.edge_src)
  );

  pct_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run_bit),
    .clk_sel(source_clock_select),
    .ev(ev.tick_src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel

  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire aw_have = aw_got_q | aw_hs;
  wire w_have = w_got_q | w_hs;
  wire do_wr = aw_have & w_have & ~bvalid_q;
  wire [7:0] wr_addr = aw_got_q ? aw_addr_q : awaddr;
  wire [31:0] wr_data = w_got_q ? w_data_q : wdata;
  wire [3:0] wr_strb = w_got_q ? w_strb_q : wstrb;
  wire wr_lane = do_wr & wr_strb[0];
  wire wr_tcr = wr_lane & (wr_addr == pct_pkg::OFF_TIMER_CTRL);
  wire wr_icr = wr_lane & (wr_addr == pct_pkg::OFF_INPUT_CTRL);
  wire wr_per = wr_lane & (wr_addr == pct_pkg::OFF_PERIOD) & ~run_bit;
  wire wr_msk = wr_lane & (wr_addr == pct_pkg::OFF_MASK);
  wire wr_map = (wr_addr == pct_pkg::OFF_TIMER_CTRL) | (wr_addr == pct_pkg::OFF_INPUT_CTRL) |
                (wr_addr == pct_pkg::OFF_PERIOD) | (wr_addr == pct_pkg::OFF_MASK);

  assign awready = ~aw_got_q & ~bvalid_q;
  assign wready = ~w_got_q & ~bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      aw_got_q <= aw_have & ~do_wr;
      w_got_q <= w_have & ~do_wr;
      if (aw_hs) begin
        aw_addr_q <= awaddr;
      end
      if (w_hs) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= pct_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_map ? pct_pkg::RESP_OKAY : pct_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  wire ar_hs = arvalid & arready;
  wire rd_stat = ar_hs & (araddr == pct_pkg::OFF_STATUS);
  wire rd_period = ar_hs & (araddr == pct_pkg::OFF_PERIOD);
  wire rd_map = (araddr == pct_pkg::OFF_TIMER_CTRL) | (araddr == pct_pkg::OFF_INPUT_CTRL) |
                (araddr == pct_pkg::OFF_PERIOD) | (araddr == pct_pkg::OFF_WIDTH) |
                (araddr == pct_pkg::OFF_STATUS) | (araddr == pct_pkg::OFF_MASK) |
                (araddr == pct_pkg::OFF_COUNT);
  wire [31:0] rd_mux =
    (araddr == pct_pkg::OFF_TIMER_CTRL) ? {26'h0, timer_control_reg_q} :
    (araddr == pct_pkg::OFF_INPUT_CTRL) ? {31'h0, edge_polarity_select_q} :
    (araddr == pct_pkg::OFF_PERIOD) ? {24'h0, period_capture_reg_q} :
    (araddr == pct_pkg::OFF_WIDTH) ? {24'h0, width_capture_reg_q} :
    (araddr == pct_pkg::OFF_STATUS) ? {30'h0, stat_q} :
    (araddr == pct_pkg::OFF_MASK) ? {30'h0, mask_q} :
    (araddr == pct_pkg::OFF_COUNT) ? {24'h0, cnt_q} : 32'h0000_0000;

  assign arready = ~rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= pct_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_map ? pct_pkg::RESP_OKAY : pct_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_comb begin
    tcr_d = timer_control_reg_q;
    if (wr_tcr) begin
      tcr_d = wr_data[pct_pkg::TCR_W-1:0];
    end
    if (stop_mode_req) begin
      tcr_d[pct_pkg::TCR_RUN] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_reg_q <= pct_pkg::TCR_RST;
      edge_polarity_select_q <= 1'b0;
      mask_q <= 2'h0;
    end else begin
      timer_control_reg_q <= tcr_d;
      if (wr_icr) begin
        edge_polarity_select_q <= wr_data[0];
      end
      if (wr_msk) begin
        mask_q <= wr_data[pct_pkg::STAT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and capture engine

  always_comb begin
    cnt_d = cnt_q;
    period_d = period_capture_reg_q;
    width_d = width_capture_reg_q;
    state_d = state_q;
    ev_cap = 1'b0;
    ev_ovf = 1'b0;
    if (wr_per) begin
      period_d = wr_data[pct_pkg::CNT_W-1:0];
    end
    case (state_q)
      pct_pkg::ST_STOP: begin
        cnt_d = pct_pkg::CNT_ZERO;
        if (run_bit) begin
          state_d = pct_pkg::ST_RUN;
        end
      end
      pct_pkg::ST_RUN: begin
        if (!run_bit) begin
          cnt_d = pct_pkg::CNT_ZERO;
          state_d = pct_pkg::ST_STOP;
        end else if (cap_mode) begin
          if (period_edge) begin
            period_d = cnt_q;
            cnt_d = pct_pkg::CNT_ZERO;
            ev_cap = 1'b1;
          end else begin
            if (width_edge) begin
              width_d = cnt_q;
            end
            if (ev.tick) begin
              if (cnt_q == pct_pkg::CNT_MAX) begin
                period_d = pct_pkg::CNT_MAX;
                cnt_d = pct_pkg::CNT_ZERO;
                ev_cap = 1'b1;
                ev_ovf = 1'b1;
                state_d = pct_pkg::ST_HOLD;
              end else begin
                cnt_d = cnt_inc;
              end
            end
          end
        end else if (tmr_step) begin
          if (cnt_inc == period_capture_reg_q) begin
            cnt_d = pct_pkg::CNT_ZERO;
            ev_cap = 1'b1;
          end else begin
            cnt_d = cnt_inc;
            if (auto_capture_enable) begin
              width_d = cnt_inc;
            end
          end
        end
      end
      pct_pkg::ST_HOLD: begin
        if (!run_bit) begin
          cnt_d = pct_pkg::CNT_ZERO;
          state_d = pct_pkg::ST_STOP;
        end else begin
          if (ev.tick) begin
            cnt_d = cnt_inc;
          end
          if (rd_period) begin
            state_d = pct_pkg::ST_RUN;
          end
        end
      end
      default: begin
        cnt_d = pct_pkg::CNT_ZERO;
        state_d = pct_pkg::ST_STOP;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= pct_pkg::CNT_ZERO;
      period_capture_reg_q <= pct_pkg::CAP_RST;
      width_capture_reg_q <= pct_pkg::CAP_RST;
      state_q <= pct_pkg::ST_STOP;
    end else begin
      cnt_q <= cnt_d;
      period_capture_reg_q <= period_d;
      width_capture_reg_q <= width_d;
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status

  wire [pct_pkg::STAT_W-1:0] stat_set = {ev_ovf, ev_cap};
  wire [pct_pkg::STAT_W-1:0] stat_keep = rd_stat ? 2'h0 : stat_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= stat_keep | stat_set;
    end
  end

  assign capture_irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  wire run_cap = (state_q == pct_pkg::ST_RUN) & run_bit & cap_mode;

  property p_count_tick;
    run_cap && ev.tick && !period_edge && cnt_q != pct_pkg::CNT_MAX |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_count_tick: assert property (p_count_tick) else $error("counter missed a source tick");

  property p_width_fall;
    run_cap && !edge_polarity_select_q && ev.fall |=> width_capture_reg_q == $past(cnt_q);
  endproperty
  a_width_fall: assert property (p_width_fall) else $error("falling edge did not load width");

  property p_period_rise;
    run_cap && !edge_polarity_select_q && ev.rise |=> period_capture_reg_q == $past(cnt_q) &&
      cnt_q == pct_pkg::CNT_ZERO && stat_q[pct_pkg::ST_CAPTURE];
  endproperty
  a_period_rise: assert property (p_period_rise) else $error("rising edge capture wrong");

  property p_inverted;
    run_cap && edge_polarity_select_q && (ev.rise || ev.fall) |=>
      ($past(ev.rise) ? width_capture_reg_q : period_capture_reg_q) == $past(cnt_q);
  endproperty
  a_inverted: assert property (p_inverted) else $error("inverted polarity capture wrong");

  property p_width_kept;
    run_cap && period_edge |=> $stable(width_capture_reg_q);
  endproperty
  a_width_kept: assert property (p_width_kept) else $error("period edge changed width");

  property p_overflow;
    run_cap && ev.tick && !period_edge && cnt_q == pct_pkg::CNT_MAX |=>
      period_capture_reg_q == pct_pkg::CNT_MAX && cnt_q == pct_pkg::CNT_ZERO &&
      stat_q[pct_pkg::ST_OVERFLOW] && state_q == pct_pkg::ST_HOLD;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow handling wrong");

  property p_hold;
    state_q == pct_pkg::ST_HOLD && !rd_period && run_bit |=>
      $stable(width_capture_reg_q) && $stable(period_capture_reg_q) && state_q == pct_pkg::ST_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("capture not frozen after overflow");

  property p_stop;
    stop_mode_req |=> !run_bit ##1 cnt_q == pct_pkg::CNT_ZERO;
  endproperty
  a_stop: assert property (p_stop) else $error("stop mode did not halt timer");

  property p_no_auto_capture_enable;
    cap_mode && !(run_cap && width_edge) |=> $stable(width_capture_reg_q);
  endproperty
  a_no_auto_capture_enable: assert property (p_no_auto_capture_enable) else $error("width changed without width edge");

  property p_start_zero;
    !run_bit ##1 run_bit |-> cnt_q == pct_pkg::CNT_ZERO;
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("counter not zero at start");

  c_period_capture: cover property (run_cap && period_edge);
  c_width_capture: cover property (run_cap && width_edge);
  c_overflow_resume: cover property (state_q == pct_pkg::ST_HOLD && rd_period);

endmodule : pct_top

/* core/pct_pkg.sv */
// Constants, types and register map of the pulse capture timer
//
// Contract
// - Capture mode counts the up-counter on the selected internal source clock.
// - Polarity 0: falling edge captures first; polarity 1: rising edge captures first.
// - Polarity 0: falling edge copies counter into width register.
// - Polarity 0: rising edge loads period, raises interrupt, clears counter.
// - Polarity 1: rising loads width; falling loads period, interrupts, clears counter.
// - Polarity 0: early rising edge loads only period; width keeps old value.
// - Polarity 1: early falling edge loads only period; width keeps old value.
// - Overflow at FF before edge: interrupt, period becomes FF, counter clears.
// - After overflow, capture and overflow detection pause until period is read.
// - Stop mode clears the run bit and halts the timer.
// - Auto-capture into width works only in timer and event modes.
package pct_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_TIMER_CTRL = 8'h00;
  localparam logic [7:0] OFF_INPUT_CTRL = 8'h04;
  localparam logic [7:0] OFF_PERIOD = 8'h08;
  localparam logic [7:0] OFF_WIDTH = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;

  // Timer control fields
  localparam int unsigned TCR_RUN = 0;
  localparam int unsigned TCR_CK_LSB = 1;
  localparam int unsigned TCR_MODE = 4;
  localparam int unsigned TCR_AUTO_CAPTURE_ENABLE = 5;
  localparam int unsigned TCR_W = 6;

  // Status and mask fields
  localparam int unsigned ST_CAPTURE = 0;
  localparam int unsigned ST_OVERFLOW = 1;
  localparam int unsigned STAT_W = 2;

  // Widths and reset values
  localparam int unsigned CNT_W = 8;
  localparam int unsigned PRE_W = 13;
  localparam logic [7:0] CAP_RST = 8'hFF;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [5:0] TCR_RST = 6'h00;
  localparam logic [2:0] CK_EXTERNAL = 3'h7;

  // Divider exponent per source clock code
  localparam logic [3:0] DIV_EXP [0:7] = '{4'hD, 4'hC, 4'hB, 4'hA, 4'h9, 4'h8, 4'h7, 4'h0};

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_STOP = 3'h1,
    ST_RUN = 3'h2,
    ST_HOLD = 3'h4
  } pct_state_t;

endpackage : pct_pkg

/* core/pct_event_if.sv */
// Input edges and source clock tick shared between timer modules
interface pct_event_if;
  logic rise;
  logic fall;
  logic tick;
  modport edge_src (output rise, output fall);
  modport tick_src (output tick);
  modport dst (input rise, input fall, input tick);
endinterface : pct_event_if

/* core/pct_edge_sync.sv */
// Pulse input synchroniser and edge detector
module pct_edge_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pulse source
  input wire logic pulse_input_pin,
  // Edge events
  pct_event_if.edge_src ev
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= pulse_input_pin;
      sync_q <= pulse_input_pin;
      last_q <= pulse_input_pin;
    end else begin
      meta_q <= pulse_input_pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign ev.rise = sync_q & ~last_q;
  assign ev.fall = ~sync_q & last_q;

  property p_pin_rise;
    @(posedge aclk) disable iff (!aresetn)
    $rose(pulse_input_pin) ##1 pulse_input_pin |-> ##1 (ev.rise && !ev.fall);
  endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("pin rise not seen as edge");

endmodule : pct_edge_sync

/* core/pct_prescaler.sv */
// Source clock divider giving one-cycle count ticks
module pct_prescaler (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic [2:0] clk_sel,
  // Tick out
  pct_event_if.tick_src ev
);

  logic [pct_pkg::PRE_W-1:0] div_q;
  wire [pct_pkg::PRE_W-1:0] div_mask;
  wire internal_sel;

  assign div_mask = ~({pct_pkg::PRE_W{1'b1}} << pct_pkg::DIV_EXP[clk_sel]);
  assign internal_sel = (clk_sel != pct_pkg::CK_EXTERNAL);

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Tick when all divided bits are ones
  assign ev.tick = run & internal_sel & ((div_q & div_mask) == div_mask);

endmodule : pct_prescaler

/* tb/pct_pulse_src.sv */
// Pulse source model driving the capture input pin
module pct_pulse_src #(
  parameter int unsigned MIN_HOLD = 129
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Command
  input wire logic go,
  input wire logic idle_lvl,
  input wire logic [15:0] len_idle,
  input wire logic [15:0] len_act,
  input wire logic [3:0] reps,
  // Pin and status
  output logic pulse_input_pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q;
  logic [15:0] lim_i;
  logic [15:0] lim_a;
  logic [3:0] rep_q;
  logic act_q;
  ////////////////////////////////////////////////////////////
  // Each level lasts longer than one source clock period
  assign lim_i = (len_idle < 16'(MIN_HOLD)) ? 16'(MIN_HOLD) : len_idle;
  assign lim_a = (len_act < 16'(MIN_HOLD)) ? 16'(MIN_HOLD) : len_act;
  assign pulse_input_pin = act_q ? ~idle_lvl : idle_lvl;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      act_q <= 1'b0;
      cnt_q <= 16'h0001;
      rep_q <= 4'h0;
    end else if (!busy) begin
      busy <= go;
      rep_q <= reps;
      cnt_q <= 16'h0001;
    end else if (cnt_q < (act_q ? lim_a : lim_i)) begin
      cnt_q <= cnt_q + 16'h0001;
    end else begin
      cnt_q <= 16'h0001;
      act_q <= ~act_q;
      rep_q <= act_q ? rep_q - 4'h1 : rep_q;
      busy <= !(act_q && rep_q == 4'h1);
    end
  end
endmodule : pct_pulse_src

/* tb/tb.sv */
// Self-checking bench for the pulse capture timer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stop_mode_req;
  logic awready, wready, bvalid, arready, rvalid, capture_irq, pin, busy, go, idle_lvl, hit;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, w_prev;
  logic [3:0] wstrb, reps;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] len_idle, len_act;
  int errors, comparisons, k;
  ////////////////////////////////////////////////////////////
  pct_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pulse_input_pin(pin), .stop_mode_req(stop_mode_req),
    .capture_irq(capture_irq));
  pct_pulse_src src (.aclk(aclk), .aresetn(aresetn), .go(go), .idle_lvl(idle_lvl), .len_idle(len_idle),
    .len_act(len_act), .reps(reps), .pulse_input_pin(pin), .busy(busy));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] in_rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    return {31'h0, (v >= lo) && (v <= hi)};
  endfunction : in_rng
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    int n;
    n = 0;
    b_t = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t && n < 100) begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      n++;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    check({31'h0, b_t}, 32'h1);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    int n;
    n = 0;
    r_t = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t && n < 100) begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      n++;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    check({31'h0, r_t}, 32'h1);
  endtask : axi_rd
  task automatic cfg(input logic pol, input logic il, input logic [31:0] ctrl, input logic [31:0] msk);
    axi_wr(pct_pkg::OFF_TIMER_CTRL, 32'h0000_001C, rs);
    idle_lvl <= il;
    axi_wr(pct_pkg::OFF_INPUT_CTRL, {31'h0, pol}, rs);
    axi_wr(pct_pkg::OFF_MASK, msk, rs);
    axi_rd(pct_pkg::OFF_STATUS, rd, rs);
    axi_wr(pct_pkg::OFF_TIMER_CTRL, ctrl, rs);
  endtask : cfg
  task automatic start_src(input logic [15:0] li, input logic [15:0] la, input logic [3:0] n);
    @(posedge aclk);
    len_idle <= li;
    len_act <= la;
    reps <= n;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask : start_src
  task automatic wait_irq(input int lim, output logic h);
    int n;
    h = 1'b0;
    for (n = 0; n < lim && !h; n++) begin
      @(negedge aclk);
      h = (capture_irq === 1'b1);
    end
  endtask : wait_irq
  task automatic wait_src(output logic h);
    h = 1'b0;
    @(negedge aclk);
    while (busy) begin
      @(negedge aclk);
      h = h || (capture_irq === 1'b1);
    end
    // Let the last edge pass the synchroniser
    repeat (4) begin
      @(negedge aclk);
      h = h || (capture_irq === 1'b1);
    end
  endtask : wait_src
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    #(25 * 90000);
    errors++;
    report_and_stop;
  end
  initial begin
    errors = 0;
    comparisons = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, stop_mode_req, go} = 8'h00;
    {awaddr, araddr, wdata, wstrb, reps, len_idle, len_act} = '0;
    wstrb = 4'hF;
    idle_lvl = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 7; k++) begin
      axi_rd(8'(4 * k), rd, rs);
      check(rd, (k == 2 || k == 3) ? 32'h0000_00FF : 32'h0000_0000);
    end
    axi_rd(8'h1C, rd, rs);
    check({30'h0, rs}, {30'h0, pct_pkg::RESP_SLVERR});
    axi_wr(pct_pkg::OFF_COUNT, 32'h0000_0055, rs);
    check({30'h0, rs}, {30'h0, pct_pkg::RESP_SLVERR});
    $display("test reset_map done");
    // Polarity 0 then 1, interrupt masked on the second pass
    for (k = 0; k < 2; k++) begin
      cfg(k[0], ~k[0], 32'h0000_001D, k[0] ? 32'h0000_0002 : 32'h0000_0001);
      start_src(16'd448, 16'd640, 4'h2);
      wait_src(hit);
      check({31'h0, hit}, {31'h0, ~k[0]});
      axi_rd(pct_pkg::OFF_STATUS, rd, rs);
      check(rd & 32'h0000_0001, 32'h0000_0001);
      axi_rd(pct_pkg::OFF_WIDTH, rd, rs);
      check(in_rng(rd, 3, 4), 32'h1);
      axi_rd(pct_pkg::OFF_PERIOD, rd, rs);
      check(in_rng(rd, 8, 9), 32'h1);
      $display("test capture pass %0d done", k);
    end
    // Period edge arrives first after start
    for (k = 0; k < 2; k++) begin
      axi_rd(pct_pkg::OFF_WIDTH, w_prev, rs);
      cfg(k[0], k[0], 32'h0000_001D, 32'h0000_0001);
      start_src(16'd320, 16'd640, 4'h1);
      wait_irq(1000, hit);
      check({31'h0, hit}, 32'h1);
      axi_rd(pct_pkg::OFF_WIDTH, rd, rs);
      check(rd, w_prev);
      axi_rd(pct_pkg::OFF_PERIOD, rd, rs);
      check(in_rng(rd, 2, 3), 32'h1);
      wait_src(hit);
      $display("test early edge %0d done", k);
    end
    // Overflow with auto-capture asked for in capture mode
    cfg(1'b0, 1'b1, 32'h0000_003D, 32'h0000_0003);
    axi_rd(pct_pkg::OFF_WIDTH, w_prev, rs);
    wait_irq(34000, hit);
    check({31'h0, hit}, 32'h1);
    axi_rd(pct_pkg::OFF_STATUS, rd, rs);
    check(rd & 32'h0000_0003, 32'h0000_0003);
    start_src(16'd448, 16'd640, 4'h1);
    wait_src(hit);
    check({31'h0, hit}, 32'h0);
    axi_rd(pct_pkg::OFF_WIDTH, rd, rs);
    check(rd, w_prev);
    axi_rd(pct_pkg::OFF_PERIOD, rd, rs);
    check(rd, 32'h0000_00FF);
    start_src(16'd448, 16'd640, 4'h1);
    wait_src(hit);
    check({31'h0, hit}, 32'h1);
    $display("test overflow done");
    // Chip stop clears the run bit and halts counting
    @(posedge aclk);
    stop_mode_req <= 1'b1;
    @(posedge aclk);
    stop_mode_req <= 1'b0;
    axi_rd(pct_pkg::OFF_TIMER_CTRL, rd, rs);
    check(rd, 32'h0000_003C);
    axi_rd(pct_pkg::OFF_COUNT, w_prev, rs);
    repeat (300) @(posedge aclk);
    axi_rd(pct_pkg::OFF_COUNT, rd, rs);
    check(rd, w_prev);
    $display("test stop done");
    // Timer mode with auto-capture of the running count
    axi_wr(pct_pkg::OFF_TIMER_CTRL, 32'h0000_002C, rs);
    axi_wr(pct_pkg::OFF_PERIOD, 32'h0000_0003, rs);
    axi_rd(pct_pkg::OFF_STATUS, rd, rs);
    axi_wr(pct_pkg::OFF_TIMER_CTRL, 32'h0000_002D, rs);
    wait_irq(1000, hit);
    check({31'h0, hit}, 32'h1);
    axi_rd(pct_pkg::OFF_WIDTH, rd, rs);
    check(rd, 32'h0000_0002);
    $display("test timer done");
    report_and_stop;
  end
endmodule : tb
